// [core/dps_consts.vh]
// Timing constants and encodings for the dual-port RAM host controller
`ifndef DPS_CONSTS_VH
`define DPS_CONSTS_VH
`define DPS_CLK_PERIOD_NS 4
`define DPS_T_SEM_WRITE_TO_READ_NS 5
`define DPS_T_SEM_UPDATE_PULSE_NS 10
`define DPS_T_PULSE_WIDTH_NS 12
`define DPS_T_WE_HIGHZ_NS 10
`define DPS_T_DATA_SETUP_NS 10
`define DPS_T_WRITE_HOLD_AFTER_RELEASE_NS 13
`define DPS_T_BLOCKED_TO_DATA_VALID_NS 15
`define DPS_T_ACCESS_NS 15
`define DPS_T_ADDR_SETUP_NS 0
`define DPS_CYC(ns) (((ns) + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_CYC_MIN1(ns) ((`DPS_CYC(ns) < 1) ? 1 : `DPS_CYC(ns))
`define DPS_SEM_TOKEN_BIT 0
`define DPS_ADDR_W 13
`define DPS_DATA_W 8
`define DPS_SEM_ADDR_W 3
`define DPS_CMD_RAM_READ 2'h0
`define DPS_CMD_RAM_WRITE 2'h1
`define DPS_CMD_SEM_REQUEST 2'h2
`define DPS_CMD_SEM_RELEASE 2'h3
`define DPS_CNT_W 4
`endif

// [core/dps_timer.v]
// Down counter that signals when a programmed cycle count has elapsed
module dps_timer (
    clk,
    rst,
    load,
    count,
    done
);
`include "dps_consts.vh"
input wire clk;
input wire rst;
input wire load;
input wire [`DPS_CNT_W-1:0] count;
output wire done;
reg [`DPS_CNT_W-1:0] cnt_reg;
assign done = (cnt_reg == 4'h0);
always @(posedge clk) begin
    if (rst) begin
        cnt_reg <= 4'h0;
    end else if (load) begin
        cnt_reg <= count;
    end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
    end
end
endmodule // dps_timer

// [core/dps_host.v]
// Host port controller for one side of an asynchronous dual-port RAM
// Function
// - Write only while select and strobe low
// - Strobe high during every address change
// - Strobe held high for reads
// - Array: select low; semaphore: sem low
// - Request semaphore by writing bit zero low
// - Wait before semaphore read-back check
// - Pulse sem select per semaphore read
// - Blocked write holds strobe after busy release
// - Stretch write pulse with output enable low (output enable is held high on writes instead, so the pulse is not stretched)
module dps_host (
    clk,
    rst,
    cmd_valid,
    cmd_op,
    cmd_addr,
    cmd_wdata,
    cmd_ready,
    rsp_valid,
    rsp_rdata,
    rsp_granted,
    mem_addr,
    mem_ce_n,
    mem_sem_n,
    mem_rw_n,
    mem_oe_n,
    mem_dq_o,
    mem_dq_oe_n,
    mem_dq_i,
    mem_busy_n,
    mem_int_n,
    mailbox_flag
);
`include "dps_consts.vh"
input wire clk;
input wire rst;
input wire cmd_valid;
input wire [1:0] cmd_op;
input wire [`DPS_ADDR_W-1:0] cmd_addr;
input wire [`DPS_DATA_W-1:0] cmd_wdata;
output reg cmd_ready;
output reg rsp_valid;
output reg [`DPS_DATA_W-1:0] rsp_rdata;
output reg rsp_granted;
output reg [`DPS_ADDR_W-1:0] mem_addr;
output reg mem_ce_n;
output reg mem_sem_n;
output reg mem_rw_n;
output reg mem_oe_n;
output reg [`DPS_DATA_W-1:0] mem_dq_o;
output reg mem_dq_oe_n;
input wire [`DPS_DATA_W-1:0] mem_dq_i;
input wire mem_busy_n;
input wire mem_int_n;
output reg mailbox_flag;

localparam integer WR_CYC = `DPS_CYC_MIN1(`DPS_T_PULSE_WIDTH_NS);
localparam integer RD_CYC = `DPS_CYC_MIN1(`DPS_T_ACCESS_NS);
localparam integer SEMW_CYC = `DPS_CYC_MIN1(`DPS_T_SEM_WRITE_TO_READ_NS);
localparam integer SEMP_CYC = `DPS_CYC_MIN1(`DPS_T_SEM_UPDATE_PULSE_NS);
localparam integer HOLD_CYC = `DPS_CYC_MIN1(`DPS_T_WRITE_HOLD_AFTER_RELEASE_NS);
localparam integer BDD_CYC = `DPS_CYC_MIN1(`DPS_T_BLOCKED_TO_DATA_VALID_NS);
localparam integer SETUP_CYC = `DPS_CYC_MIN1(`DPS_T_ADDR_SETUP_NS);

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_SETUP = 3'h1;
localparam [2:0] S_WRITE = 3'h2;
localparam [2:0] S_READ = 3'h3;
localparam [2:0] S_HOLD = 3'h4;
localparam [2:0] S_SEMGAP = 3'h5;
localparam [2:0] S_SEMRD = 3'h6;
localparam [2:0] S_DONE = 3'h7;

reg [2:0] state_reg;
reg [1:0] op_reg;
reg busy_meta_reg;
reg busy_sync_reg;
reg int_meta_reg;
reg int_sync_reg;
reg [`DPS_DATA_W-1:0] dq_meta_reg;
reg [`DPS_DATA_W-1:0] dq_sync_reg;
reg was_blocked_reg;
reg tmr_load;
reg [3:0] tmr_count;
wire tmr_done;
wire is_write;
wire is_sem;

assign is_write = (op_reg != `DPS_CMD_RAM_READ);
assign is_sem = op_reg[1];

dps_timer u_timer (
    .clk(clk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
);

// Two-stage synchronisers for pins from the asynchronous device
always @(posedge clk) begin
    if (rst) begin
        busy_meta_reg <= 1'b1;
        busy_sync_reg <= 1'b1;
        int_meta_reg <= 1'b1;
        int_sync_reg <= 1'b1;
        dq_meta_reg <= 8'h00;
        dq_sync_reg <= 8'h00;
        mailbox_flag <= 1'b0;
    end else begin
        busy_meta_reg <= mem_busy_n;
        busy_sync_reg <= busy_meta_reg;
        int_meta_reg <= mem_int_n;
        int_sync_reg <= int_meta_reg;
        dq_meta_reg <= mem_dq_i;
        dq_sync_reg <= dq_meta_reg;
        mailbox_flag <= ~int_sync_reg;
    end
end

always @* begin
    tmr_load = 1'b0;
    tmr_count = 4'h0;
    case (state_reg)
        S_IDLE: begin
            tmr_load = cmd_valid;
            tmr_count = SETUP_CYC[3:0];
        end
        S_SETUP: begin
            if (tmr_done) begin
                tmr_load = 1'b1;
                tmr_count = is_write ? WR_CYC[3:0] : RD_CYC[3:0];
            end
        end
        S_WRITE: begin
            if (tmr_done && busy_sync_reg) begin
                tmr_load = 1'b1;
                tmr_count = was_blocked_reg ? HOLD_CYC[3:0] : (is_sem ? SEMW_CYC[3:0] : 4'h1);
            end
        end
        S_READ: begin
            if (!busy_sync_reg) begin
                tmr_load = 1'b1;
                tmr_count = BDD_CYC[3:0];
            end
        end
        S_HOLD: begin
            if (tmr_done) begin
                tmr_load = 1'b1;
                tmr_count = is_sem ? SEMW_CYC[3:0] : 4'h1;
            end
        end
        S_SEMGAP: begin
            if (tmr_done) begin
                tmr_load = 1'b1;
                tmr_count = SEMP_CYC[3:0];
            end
        end
        default: begin
            tmr_load = 1'b0;
            tmr_count = 4'h0;
        end
    endcase
end

always @(posedge clk) begin
    if (rst) begin
        state_reg <= S_IDLE;
        op_reg <= 2'h0;
        was_blocked_reg <= 1'b0;
        cmd_ready <= 1'b1;
        rsp_valid <= 1'b0;
        rsp_rdata <= 8'h00;
        rsp_granted <= 1'b0;
        mem_addr <= 13'h0000;
        mem_ce_n <= 1'b1;
        mem_sem_n <= 1'b1;
        mem_rw_n <= 1'b1;
        mem_oe_n <= 1'b1;
        mem_dq_o <= 8'h00;
        mem_dq_oe_n <= 1'b1;
    end else begin
        rsp_valid <= 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (cmd_valid) begin
                    // Address moves only with strobe high
                    op_reg <= cmd_op;
                    mem_addr <= cmd_addr;
                    mem_rw_n <= 1'b1;
                    mem_oe_n <= 1'b1;
                    mem_dq_o <= cmd_wdata;
                    if (cmd_op == `DPS_CMD_SEM_REQUEST) begin
                        mem_dq_o[`DPS_SEM_TOKEN_BIT] <= 1'b0;
                    end else if (cmd_op == `DPS_CMD_SEM_RELEASE) begin
                        mem_dq_o[`DPS_SEM_TOKEN_BIT] <= 1'b1;
                    end
                    mem_ce_n <= cmd_op[1];
                    mem_sem_n <= ~cmd_op[1];
                    was_blocked_reg <= 1'b0;
                    cmd_ready <= 1'b0;
                    state_reg <= S_SETUP;
                end
            end
            S_SETUP: begin
                if (tmr_done) begin
                    if (is_write) begin
                        // OE held high so write pulse needs no stretch
                        mem_dq_oe_n <= 1'b0;
                        mem_rw_n <= 1'b0;
                        state_reg <= S_WRITE;
                    end else begin
                        mem_rw_n <= 1'b1;
                        mem_oe_n <= 1'b0;
                        state_reg <= S_READ;
                    end
                end
            end
            S_WRITE: begin
                if (!busy_sync_reg) begin
                    was_blocked_reg <= 1'b1;
                end
                if (tmr_done && busy_sync_reg) begin
                    if (was_blocked_reg) begin
                        state_reg <= S_HOLD;
                    end else begin
                        mem_rw_n <= 1'b1;
                        state_reg <= is_sem ? S_SEMGAP : S_DONE;
                        mem_ce_n <= 1'b1;
                        mem_sem_n <= 1'b1;
                    end
                end
            end
            S_HOLD: begin
                if (tmr_done) begin
                    mem_rw_n <= 1'b1;
                    mem_ce_n <= 1'b1;
                    mem_sem_n <= 1'b1;
                    state_reg <= is_sem ? S_SEMGAP : S_DONE;
                end
            end
            S_SEMGAP: begin
                mem_dq_oe_n <= 1'b1;
                if (tmr_done) begin
                    // Fresh sem select pulse for the check read
                    mem_sem_n <= 1'b0;
                    mem_oe_n <= 1'b0;
                    state_reg <= S_SEMRD;
                end
            end
            S_SEMRD: begin
                if (tmr_done) begin
                    rsp_rdata <= dq_sync_reg;
                    rsp_granted <= ~dq_sync_reg[`DPS_SEM_TOKEN_BIT];
                    rsp_valid <= 1'b1;
                    mem_sem_n <= 1'b1;
                    mem_oe_n <= 1'b1;
                    cmd_ready <= 1'b1;
                    state_reg <= S_IDLE;
                end
            end
            S_READ: begin
                if (tmr_done && busy_sync_reg) begin
                    rsp_rdata <= dq_sync_reg;
                    rsp_granted <= 1'b0;
                    rsp_valid <= 1'b1;
                    mem_ce_n <= 1'b1;
                    mem_oe_n <= 1'b1;
                    cmd_ready <= 1'b1;
                    state_reg <= S_IDLE;
                end
            end
            default: begin
                mem_dq_oe_n <= 1'b1;
                rsp_valid <= 1'b1;
                rsp_granted <= 1'b0;
                cmd_ready <= 1'b1;
                state_reg <= S_IDLE;
            end
        endcase
    end
end
endmodule // dps_host

// [tb/dps_host_assertions.sv]
// Pin-level checks on the dual-port RAM host controller
`include "dps_consts.vh"
module dps_host_assertions (
    input logic clk,
    input logic rst,
    input logic [`DPS_ADDR_W-1:0] mem_addr,
    input logic mem_ce_n,
    input logic mem_sem_n,
    input logic mem_rw_n,
    input logic mem_oe_n,
    input logic mem_dq_oe_n,
    input logic mem_busy_n,
    input logic mem_int_n,
    input logic mailbox_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_one_select: assert property (!mem_rw_n |-> mem_ce_n != mem_sem_n)
        else $error("write without exactly one select");
    chk_addr_steady: assert property (!mem_rw_n |-> $stable(mem_addr))
        else $error("address moved during write");
    chk_read_strobe: assert property (!mem_oe_n |-> mem_rw_n)
        else $error("read with write strobe low");
    chk_write_drive: assert property (!mem_rw_n |-> !mem_dq_oe_n && mem_oe_n)
        else $error("write without data drive or with oe low");
    chk_sem_gap: assert property ($fell(mem_sem_n) && !mem_oe_n |-> $past(mem_sem_n) && $past(mem_sem_n, 2))
        else $error("semaphore read too soon");
    chk_sem_pulse: assert property ($fell(mem_sem_n) && !mem_oe_n |-> (!mem_sem_n && !mem_oe_n) [*3])
        else $error("semaphore read pulse short");
    chk_hold_after: assert property ($rose(mem_busy_n) && !mem_rw_n |-> !mem_rw_n [*4])
        else $error("write ended early after busy");
    chk_busy_block: assert property (!mem_rw_n && !mem_busy_n && !$past(mem_busy_n, 3) |=> !mem_rw_n)
        else $error("write ended while busy");
    chk_mbox_set: assert property ($fell(mem_int_n) |-> ##[1:4] mailbox_flag)
        else $error("mailbox flag not set");
    chk_mbox_clear: assert property ($rose(mem_int_n) |-> ##[1:4] !mailbox_flag)
        else $error("mailbox flag not cleared");
endmodule // dps_host_assertions

bind dps_host dps_host_assertions u_chk (.clk, .rst, .mem_addr, .mem_ce_n, .mem_sem_n,
    .mem_rw_n, .mem_oe_n, .mem_dq_oe_n, .mem_busy_n, .mem_int_n, .mailbox_flag);

// [tb/dps_dev_model.sv]
// Behavioural device port with array, semaphores, busy and mailbox
`include "dps_consts.vh"
module dps_dev_model (
    input logic clk,
    input logic [`DPS_ADDR_W-1:0] addr,
    input logic ce_n,
    input logic sem_n,
    input logic rw_n,
    input logic oe_n,
    input logic [`DPS_DATA_W-1:0] dq_w,
    input logic dq_oe_n,
    input logic blk,
    input logic oth,
    input logic oth_int,
    output logic [`DPS_DATA_W-1:0] dq_r,
    output logic busy_n,
    output logic int_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];
    logic [7:0] own_reg = 8'h00;
    logic int_reg = 1'h0;
    wire ram = !ce_n && sem_n;
    wire sem = ce_n && !sem_n;
    // Other port parked on the same location
    assign busy_n = !(blk && !ce_n);
    wire wr = !rw_n && busy_n;
    wire rd = !oe_n && rw_n && busy_n && (ram || sem);
    wire [7:0] bus = !dq_oe_n ? dq_w : dq_r;
    // Junk that changes every half cycle when not driving
    assign dq_r = !rd ? {8{clk}} ^ 8'h5A : ram ? mem[addr[3:0]] : {8{!own_reg[addr[2:0]]}};
    always @(negedge (ram && wr)) mem[addr[3:0]] <= bus;
    always @(negedge (sem && wr)) own_reg[addr[2:0]] <= !bus[0] && !oth;
    always @(posedge clk)
        if (oth_int)
            int_reg <= 1'h1;
        else if (rd && ram && &addr)
            int_reg <= 1'h0;
    assign int_n = !int_reg;
endmodule // dps_dev_model

// [tb/test_dps_host.sv]
// Self-checking bench for the dual-port RAM host controller
`include "dps_consts.vh"
module test_dps_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst = 1'h1, cmd_valid = 1'h0, blk = 1'h0, oth = 1'h0, oth_int = 1'h0;
    logic [1:0] cmd_op = 2'h0;
    logic [`DPS_ADDR_W-1:0] cmd_addr = 13'h0000;
    logic [`DPS_DATA_W-1:0] cmd_wdata = 8'h00;
    wire cmd_ready, rsp_valid, rsp_granted, mem_ce_n, mem_sem_n, mem_rw_n, mem_oe_n;
    wire mem_dq_oe_n, mem_busy_n, mem_int_n, mailbox_flag;
    wire [`DPS_DATA_W-1:0] rsp_rdata, mem_dq_o, mem_dq_i;
    wire [`DPS_ADDR_W-1:0] mem_addr;
    int mismatches = 0, cmp_count = 0;
    // Row: other holds, op, address, write data, read data, granted
    logic [43:0] rows [7] = '{44'h0_1_0003_3C_00_0, 44'h0_0_0003_00_3C_0,
        44'h1_2_0001_00_FF_0, 44'h0_2_0001_00_00_1, 44'h0_3_0001_01_FF_0,
        44'h0_2_0007_00_00_1, 44'h0_3_0007_01_FF_0};
    always #2 clk = ~clk;
    dps_host u_dut (.clk, .rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready,
        .rsp_valid, .rsp_rdata, .rsp_granted, .mem_addr, .mem_ce_n, .mem_sem_n, .mem_rw_n,
        .mem_oe_n, .mem_dq_o, .mem_dq_oe_n, .mem_dq_i, .mem_busy_n, .mem_int_n, .mailbox_flag);
    dps_dev_model u_dev (.clk, .addr(mem_addr), .ce_n(mem_ce_n), .sem_n(mem_sem_n),
        .rw_n(mem_rw_n), .oe_n(mem_oe_n), .dq_w(mem_dq_o), .dq_oe_n(mem_dq_oe_n), .blk,
        .oth, .oth_int, .dq_r(mem_dq_i), .busy_n(mem_busy_n), .int_n(mem_int_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [1:0] o, input logic [12:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_op <= o;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'h0;
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'h1 && n < 300);
        if (n >= 300)
            mismatches++;
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #40000;
        mismatches++;
        results;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        foreach (rows[i]) begin
            oth <= rows[i][40];
            run(rows[i][37:36], rows[i][32:20], rows[i][19:12]);
            chk({7'h0, rsp_granted}, {4'h0, rows[i][3:0]});
            if (rows[i][37:36] != 2'h1)
                chk(rsp_rdata, rows[i][11:4]);
            $display("row %0d done", i);
        end
        for (int k = 1; k >= 0; k--) begin
            blk <= 1'h1;
            fork
                run(k[1:0], 13'h0005, 8'h77);
                begin
                    repeat (12) @(posedge clk);
                    chk({7'h0, k ? mem_rw_n : mem_oe_n}, 8'h00);
                    blk <= 1'h0;
                end
            join
        end
        chk(rsp_rdata, 8'h77);
        $display("blocked access done");
        oth_int <= 1'h1;
        @(posedge clk) oth_int <= 1'h0;
        repeat (6) @(posedge clk);
        chk({7'h0, mailbox_flag}, 8'h01);
        run(2'h0, 13'h1FFF, 8'h00);
        repeat (6) @(posedge clk);
        chk({7'h0, mailbox_flag}, 8'h00);
        $display("mailbox done");
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_op <= 2'h1;
        repeat (4) @(posedge clk);
        rst <= 1'h1;
        cmd_valid <= 1'h0;
        repeat (2) @(negedge clk);
        chk({2'h0, mem_ce_n, mem_sem_n, mem_rw_n, mem_oe_n, mem_dq_oe_n, cmd_ready}, 8'h3F);
        @(posedge clk) rst <= 1'h0;
        run(2'h0, 13'h0003, 8'h00);
        chk(rsp_rdata, 8'h3C);
        $display("reset abort done");
        results;
    end
endmodule // test_dps_host
